/* rtl/sfp_pin_front.sv */
// Pin-level front end of a serial flash: select, pause, reset, write protect,
// and the shift path for single, dual and quad transfers.
// Assumes the serial clock and all pins are asynchronous to clk and much slower.
`timescale 1ns/1ps
`include "sfp_consts.svh"

module sfp_pin_front
    import sfp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  data_line_i,
    output logic      [3:0]  data_line_o,
    output logic      [3:0]  data_line_oe,
    input  wire logic        reset_pin_n,
    input  wire logic        reset_pin_fitted,
    input  wire sfp_cfg_t    cfg,
    input  wire sfp_width_t  width,
    input  wire logic        out_phase,
    input  wire logic        internal_busy,
    output logic             selected,
    output logic             paused,
    output logic             dev_reset,
    output logic             abort_internal,
    output logic             quad_refused,
    output logic             status_write_ok,
    output sfp_region_t      region,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic      [7:0]  rx_data,
    output logic             rx_overrun,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic [7:0]  tx_data
);

    localparam int RESET_CYC = `SFP_RESET_CYC;

    function automatic sfp_region_t calc_region(input sfp_cfg_t c);
        logic [2:0]  bp;
        logic [2:0]  e;
        logic [10:0] sz;
        sfp_region_t r;
        bp = {c.protect_range_bit2, c.protect_range_bit1, c.protect_range_bit0};
        e  = (bp > `SFP_SEC_MAX_EXP) ? `SFP_SEC_MAX_EXP : bp;
        if (bp == 3'h0)
            sz = 11'h000;
        else if (c.protect_sector_granule)
            sz = 11'h001 << (e - 3'h1);
        else
            sz = `SFP_BLOCK_SECTORS << (bp - 3'h1);
        if (sz > `SFP_SECTORS)
            sz = `SFP_SECTORS;
        r.lo = c.protect_top_bottom ? 11'h000 : `SFP_SECTORS - sz;
        r.hi = c.protect_top_bottom ? sz : `SFP_SECTORS;
        if (c.protect_complement)
        begin
            r.lo = c.protect_top_bottom ? sz : 11'h000;
            r.hi = c.protect_top_bottom ? `SFP_SECTORS : `SFP_SECTORS - sz;
        end
        r.locked = 1'b0;
        return r;
    endfunction : calc_region

    // Two-flop synchronisers; select resets low so no false fall follows reset
    logic [1:0] sclk_q;
    logic [1:0] cs_q;
    logic [1:0] rpin_q;
    logic [3:0] dl_s1_q;
    logic [3:0] dl_q;
    logic       sclk_d3_q;
    logic       cs_d3_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q    <= 2'b00;
            cs_q      <= 2'b00;
            rpin_q    <= 2'b11;
            dl_s1_q   <= 4'hf;
            dl_q      <= 4'hf;
            sclk_d3_q <= 1'b0;
            cs_d3_q   <= 1'b0;
        end
        else if (clk_en)
        begin
            sclk_q    <= {sclk_q[0], sclk};
            cs_q      <= {cs_q[0], cs_n};
            rpin_q    <= {rpin_q[0], reset_pin_n | ~reset_pin_fitted};
            dl_s1_q   <= data_line_i;
            dl_q      <= dl_s1_q;
            sclk_d3_q <= sclk_q[1];
            cs_d3_q   <= cs_q[1];
        end
    end

    logic sclk_s;
    logic cs_s;
    logic rise;
    logic fall;
    logic cs_fall;
    assign sclk_s  = sclk_q[1];
    assign cs_s    = cs_q[1];
    assign rise    = sclk_s & ~sclk_d3_q;
    assign fall    = ~sclk_s & sclk_d3_q;
    assign cs_fall = ~cs_s & cs_d3_q;

    // Pin roles follow four-line enable and the pause-or-reset select
    logic qe;
    logic shared_rst;
    logic pause_req;
    logic rst_low;
    assign qe         = cfg.four_line_enable;
    assign shared_rst = ~qe & cfg.pause_or_reset_sel;
    assign pause_req  = ~qe & ~cfg.pause_or_reset_sel & ~dl_q[`SFP_DL_PAUSE]
                        & ~cs_s;
    assign rst_low    = ~rpin_q[1] | (shared_rst & ~dl_q[`SFP_DL_PAUSE]);

    // Reset low is honoured at once for commands; power-on state after the minimum
    logic [`SFP_CNT_W-1:0] rst_cnt_q;
    logic                  dev_reset_q;
    logic                  abort_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_cnt_q   <= '0;
            dev_reset_q <= 1'b0;
            abort_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            abort_q <= 1'b0;
            if (!rst_low)
            begin
                rst_cnt_q   <= '0;
                dev_reset_q <= 1'b0;
            end
            else if (rst_cnt_q != `SFP_CNT_W'(RESET_CYC - 1))
                rst_cnt_q <= rst_cnt_q + `SFP_CNT_W'(1);
            else if (!dev_reset_q)
            begin
                dev_reset_q <= 1'b1;
                abort_q     <= internal_busy;
            end
        end
    end

    // Armed by a select falling edge after power-up or a completed reset
    logic armed_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            armed_q <= 1'b0;
        else if (clk_en)
        begin
            if (dev_reset_q)
                armed_q <= 1'b0;
            else if (cs_fall)
                armed_q <= 1'b1;
        end
    end

    // Pause only changes while the serial clock is low, except that deselection clears it at once
    logic pause_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pause_q <= 1'b0;
        else if (clk_en)
        begin
            if (cs_s)
                pause_q <= 1'b0;
            else if (!sclk_s)
                pause_q <= pause_req;
        end
    end

    logic       active;
    sfp_width_t eff_w;
    assign active = armed_q & ~cs_s & ~pause_q & ~rst_low;
    assign eff_w  = (width == SFP_W_QUAD && !qe) ? SFP_W_SINGLE : width;

    // Input shifter; state is held untouched through a pause
    logic [7:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic [7:0] rx_hold_q;
    logic       rx_hold_v_q;
    logic       rx_overrun_q;
    logic [7:0] rx_next;
    logic [3:0] rx_step;

    always_comb
    begin
        rx_next = rx_sh_q;
        rx_step = 4'h1;
        unique case (eff_w)
            SFP_W_SINGLE:
                rx_next = {rx_sh_q[6:0], dl_q[`SFP_DL_SINGLE_IN]};
            SFP_W_DUAL:
            begin
                rx_next = {rx_sh_q[5:0], dl_q[1:0]};
                rx_step = 4'h2;
            end
            SFP_W_QUAD:
            begin
                rx_next = {rx_sh_q[3:0], dl_q};
                rx_step = 4'h4;
            end
            default:
                rx_next = rx_sh_q;
        endcase
    end

    logic buf_in_ready;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_sh_q      <= 8'h00;
            rx_cnt_q     <= 4'h0;
            rx_hold_q    <= 8'h00;
            rx_hold_v_q  <= 1'b0;
            rx_overrun_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rx_hold_v_q && buf_in_ready)
                rx_hold_v_q <= 1'b0;
            if (cs_fall)
                rx_overrun_q <= 1'b0;
            if (cs_s || dev_reset_q)
                rx_cnt_q <= 4'h0;
            else if (active && rise && !out_phase)
            begin
                rx_sh_q <= rx_next;
                if (rx_cnt_q + rx_step >= `SFP_BYTE_BITS)
                begin
                    rx_cnt_q    <= 4'h0;
                    rx_hold_q   <= rx_next;
                    rx_hold_v_q <= 1'b1;
                    if (rx_hold_v_q && !buf_in_ready)
                        rx_overrun_q <= 1'b1;
                end
                else
                    rx_cnt_q <= rx_cnt_q + rx_step;
            end
        end
    end

    // Two-entry buffer between the shifter and the receiver
    logic [7:0] buf_mem_q [2];
    logic       wr_ptr_q;
    logic       rd_ptr_q;
    logic [1:0] buf_cnt_q;
    logic       buf_push;
    logic       buf_pop;
    assign buf_in_ready = (buf_cnt_q != 2'h2);
    assign buf_push     = rx_hold_v_q & buf_in_ready;
    assign buf_pop      = rx_valid & rx_ready;
    assign rx_valid     = (buf_cnt_q != 2'h0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_mem_q[0] <= 8'h00;
            buf_mem_q[1] <= 8'h00;
            wr_ptr_q     <= 1'b0;
            rd_ptr_q     <= 1'b0;
            buf_cnt_q    <= 2'h0;
            rx_data      <= 8'h00;
        end
        else if (clk_en)
        begin
            if (buf_push)
            begin
                buf_mem_q[wr_ptr_q] <= rx_hold_q;
                wr_ptr_q            <= ~wr_ptr_q;
            end
            if (buf_pop)
                rd_ptr_q <= ~rd_ptr_q;
            buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
            rx_data   <= (buf_pop || buf_cnt_q == 2'h0) ?
                         (buf_push ? rx_hold_q : buf_mem_q[~rd_ptr_q])
                         : buf_mem_q[rd_ptr_q];
        end
    end

    // Output shifter; next byte is taken when the current one is spent
    logic [7:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    assign tx_ready = active & out_phase & fall & (tx_cnt_q == 4'h0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_sh_q     <= 8'h00;
            tx_cnt_q    <= 4'h0;
            data_line_o <= 4'h0;
        end
        else if (clk_en)
        begin
            if (cs_s || dev_reset_q)
                tx_cnt_q <= 4'h0;
            else if (active && out_phase && fall)
            begin
                logic [7:0] b;
                b = (tx_cnt_q == 4'h0) ? (tx_valid ? tx_data : 8'hff) : tx_sh_q;
                unique case (eff_w)
                    SFP_W_DUAL:
                    begin
                        data_line_o <= {2'b00, b[7:6]};
                        tx_sh_q     <= {b[5:0], 2'b00};
                        tx_cnt_q    <= (tx_cnt_q == 4'h6) ? 4'h0 : tx_cnt_q + 4'h2;
                    end
                    SFP_W_QUAD:
                    begin
                        data_line_o <= b[7:4];
                        tx_sh_q     <= {b[3:0], 4'h0};
                        tx_cnt_q    <= (tx_cnt_q == 4'h4) ? 4'h0 : tx_cnt_q + 4'h4;
                    end
                    default:
                    begin
                        data_line_o <= {2'b00, b[7], 1'b0};
                        tx_sh_q     <= {b[6:0], 1'b0};
                        tx_cnt_q    <= (tx_cnt_q == 4'h7) ? 4'h0 : tx_cnt_q + 4'h1;
                    end
                endcase
            end
        end
    end

    // Drivers only in the output phase of a selected, unpaused transfer
    always_comb
    begin
        data_line_oe = 4'h0;
        if (active && out_phase)
        begin
            unique case (eff_w)
                SFP_W_DUAL: data_line_oe = 4'h3;
                SFP_W_QUAD: data_line_oe = 4'hf;
                default:    data_line_oe = 4'h2;
            endcase
        end
    end

    // Write protect and protected range; quad use takes the pin away
    logic wp_blocks;
    assign wp_blocks = ~qe & ~dl_q[`SFP_DL_WP] & (cfg.status_lock_bits == `SFP_LOCK_HW);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_write_ok <= 1'b1;
            region          <= '0;
            quad_refused    <= 1'b0;
        end
        else if (clk_en)
        begin
            status_write_ok <= ~wp_blocks & ~cfg.status_lock_bits[1];
            region          <= calc_region(cfg);
            region.locked   <= wp_blocks | cfg.status_lock_bits[1];
            quad_refused    <= (width == SFP_W_QUAD) & ~qe;
        end
    end

    // Internal work is not tied to chip select; only reset cancels it
    assign abort_internal = abort_q;
    assign selected       = armed_q & ~cs_s;
    assign paused         = pause_q;
    assign dev_reset      = dev_reset_q;
    assign rx_overrun     = rx_overrun_q;

    chk_desel_released: assert property (@(posedge clk) disable iff (!rst_n)
        cs_s |-> data_line_oe == 4'h0)
        else $error("drivers on while deselected");

    chk_arm_needs_edge: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(armed_q) |-> $past(cs_fall))
        else $error("armed without select edge");

    chk_pause_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        pause_q |-> data_line_oe == 4'h0 && !tx_ready)
        else $error("activity during pause");

    chk_pause_clk_low: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(pause_q) && !$past(cs_s) |-> !$past(sclk_s))
        else $error("pause moved with clock high");

    chk_quad_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !qe |-> data_line_oe[3:2] == 2'b00)
        else $error("upper lines driven without enable");

    chk_no_pause_quad: assert property (@(posedge clk) disable iff (!rst_n)
        qe |-> ##1 !pause_q)
        else $error("pause with four-line enable");

    chk_reset_time: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && $rose(dev_reset_q) |-> $past(rst_low, 2))
        else $error("reset without low pin");

    chk_wp_status: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && wp_blocks |=> !status_write_ok)
        else $error("status write allowed under protect");

    chk_single_out: assert property (@(posedge clk) disable iff (!rst_n)
        eff_w == SFP_W_SINGLE && data_line_oe != 4'h0 |-> data_line_oe == 4'h2)
        else $error("single mode drives wrong line");

endmodule : sfp_pin_front

/* rtl/sfp_consts.svh */
// Offsets, field positions, reset values and timing counts of the pin front end.
// Assumes a single core clock given in MHz below.
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

`define SFP_CLK_MHZ        125
`define SFP_T_RESET_NS     1000
`define SFP_RESET_CYC      ((`SFP_T_RESET_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_CNT_W          8
`define SFP_SECTORS        11'h400
`define SFP_BLOCK_SECTORS  11'h010
`define SFP_SEC_MAX_EXP    3'h4
`define SFP_LOCK_HW        2'h1
`define SFP_BYTE_BITS      4'h8
`define SFP_DL_SINGLE_IN   0
`define SFP_DL_SINGLE_OUT  1
`define SFP_DL_WP          2
`define SFP_DL_PAUSE       3

`endif

/* rtl/sfp_pkg.sv */
// Types shared by the serial flash pin front end.
// Used together with sfp_consts.svh.
package sfp_pkg;

    typedef enum logic [1:0]
    {
        SFP_W_SINGLE = 2'b00,
        SFP_W_DUAL   = 2'b01,
        SFP_W_QUAD   = 2'b10
    } sfp_width_t;

    typedef struct packed
    {
        logic       four_line_enable;
        logic       pause_or_reset_sel;
        logic [1:0] status_lock_bits;
        logic       protect_complement;
        logic       protect_sector_granule;
        logic       protect_top_bottom;
        logic       protect_range_bit2;
        logic       protect_range_bit1;
        logic       protect_range_bit0;
    } sfp_cfg_t;

    typedef struct packed
    {
        logic [10:0] lo;
        logic [10:0] hi;
        logic        locked;
    } sfp_region_t;

endpackage : sfp_pkg

/* verif/sfp_ctrl_model.sv */
// Serial bus controller model: serial clock, select and data lines, mode 3.
// Assumes the bench resolves every pin from both enables, with pull-ups.
`timescale 1ns/1ps
module sfp_ctrl_model
#(
    parameter logic CS_INIT = 1'b1
)
(
    input  wire logic       clk,
    input  wire logic [3:0] pin,
    output logic            sclk,
    output logic            cs_n,
    output logic      [3:0] ctl_d,
    output logic      [3:0] ctl_oe
);
    logic       wp_n   = 1'b1;
    logic       hold_n = 1'b1;
    logic       quad   = 1'b0;
    logic [3:0] dat    = 4'h0;
    logic [3:0] en     = 4'h0;

    // Lines 2 and 3 stay write protect and pause outside quad frames
    assign ctl_d  = quad ? dat : {hold_n, wp_n, dat[1:0]};
    assign ctl_oe = quad ? en : {2'b11, en[1:0]};

    initial
    begin
        sclk = 1'b1;
        cs_n = CS_INIT;
    end

    task automatic frame(input logic sel_n);
        @(negedge clk);
        cs_n = sel_n;
        repeat (10) @(negedge clk);
    endtask : frame

    // Clock idles high, so the first edge of a frame is a falling one
    task automatic shift(input int lanes, input bit rd, input logic [7:0] wv,
                         input int n, output logic [7:0] rv);
        rv = 8'h00;
        quad = (lanes == 4);
        for (int e = 0; e < n; e++)
        begin
            @(negedge clk);
            sclk = 1'b0;
            en = rd ? 4'h0 : (lanes == 4 ? 4'hf : lanes == 2 ? 4'h3 : 4'h1);
            dat = lanes == 4 ? wv[7:4] : lanes == 2 ? {2'b00, wv[7:6]} : {3'b000, wv[7]};
            wv = wv << lanes;
            repeat (10) @(negedge clk);
            rv = (rv << lanes) | (lanes == 4 ? pin : lanes == 2 ? pin & 4'h3 : {3'b000, pin[1]});
            sclk = 1'b1;
            repeat (9) @(negedge clk);
        end
        en = 4'h0;
        quad = 1'b0;
    endtask : shift
endmodule : sfp_ctrl_model

/* verif/sfp_pin_front_tb_top.sv */
// Bench of the serial flash pin front end: arming, widths, read, buffer,
// pause, write protect, protect range and both reset pins.
// Assumes sfp_ctrl_model on the pins; every released line is pulled up.
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_pin_front_tb_top
    import sfp_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        clk_en;
    logic        reset_pin_n;
    logic        reset_pin_fitted;
    sfp_cfg_t    cfg;
    sfp_width_t  width;
    logic        out_phase;
    logic        internal_busy;
    logic        rx_ready;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic [3:0]  dl_o, dl_oe, ctl_d, ctl_oe, pin;
    logic        sclk, cs_n, selected, paused, dev_reset, abort_internal, quad_refused;
    logic        status_write_ok, rx_valid, rx_overrun, tx_ready;
    logic [7:0]  rx_data, rv;
    sfp_region_t region;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          abort_cnt = 0;
    int          tx_taken = 0;

    always #4 clk = ~clk;
    always @(posedge clk) if (tx_ready === 1'b1) tx_taken <= tx_taken + 1;
    assign pin = (dl_oe & dl_o) | (~dl_oe & ctl_oe & ctl_d) | (~dl_oe & ~ctl_oe);
    always @(posedge clk) if (abort_internal === 1'b1) abort_cnt <= abort_cnt + 1;

    sfp_pin_front i_sfp_pin_front (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sclk(sclk),
        .cs_n(cs_n), .data_line_i(pin), .data_line_o(dl_o), .data_line_oe(dl_oe),
        .reset_pin_n(reset_pin_n), .reset_pin_fitted(reset_pin_fitted), .cfg(cfg),
        .width(width), .out_phase(out_phase), .internal_busy(internal_busy),
        .selected(selected), .paused(paused), .dev_reset(dev_reset),
        .abort_internal(abort_internal), .quad_refused(quad_refused),
        .status_write_ok(status_write_ok), .region(region), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

    // Powers up with select already low, so arming needs a fresh falling edge
    sfp_ctrl_model #(.CS_INIT(1'b0)) i_sfp_ctrl_model (.clk(clk), .pin(pin),
        .sclk(sclk), .cs_n(cs_n), .ctl_d(ctl_d), .ctl_oe(ctl_oe));

    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        while (rx_valid !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 300)
        begin
            error_cnt++;
            print_verdict();
        end
        check(rx_data, exp);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
        @(negedge clk);
    endtask : pop

    task automatic send(input int lanes, input logic [7:0] v);
        i_sfp_ctrl_model.frame(1'b0);
        i_sfp_ctrl_model.shift(lanes, 1'b0, v, 8 / lanes, rv);
        i_sfp_ctrl_model.frame(1'b1);
    endtask : send

    task automatic t_arm;
        i_sfp_ctrl_model.shift(1, 1'b0, 8'h5a, 8, rv);
        cyc(20);
        check(rx_valid, 1'b0);
        check(selected, 1'b0);
        i_sfp_ctrl_model.frame(1'b1);
        i_sfp_ctrl_model.frame(1'b0);
        check(selected, 1'b1);
        i_sfp_ctrl_model.frame(1'b1);
    endtask : t_arm

    // A frozen core misses a whole byte but keeps its selection
    task automatic t_freeze;
        i_sfp_ctrl_model.frame(1'b0);
        clk_en = 1'b0;
        i_sfp_ctrl_model.shift(1, 1'b0, 8'h55, 8, rv);
        clk_en = 1'b1;
        cyc(4);
        check(rx_valid, 1'b0);
        check(selected, 1'b1);
        i_sfp_ctrl_model.frame(1'b1);
    endtask : t_freeze

    task automatic t_widths;
        cfg.four_line_enable = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            width = sfp_width_t'(k);
            send(1 << k, 8'h3c + 8'(k));
            pop(8'h3c + 8'(k));
        end
        cfg.four_line_enable = 1'b0;
        cyc(4);
        check(quad_refused, 1'b1);
        send(1, 8'h81);
        pop(8'h81);
    endtask : t_widths

    task automatic t_read;
        cfg.four_line_enable = 1'b1;
        tx_valid = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            width = sfp_width_t'(k);
            tx_data = 8'ha7 ^ 8'(k);
            i_sfp_ctrl_model.frame(1'b0);
            check(dl_oe, 4'h0);
            out_phase = 1'b1;
            cyc(4);
            check(dl_oe, k == 0 ? 4'h2 : k == 1 ? 4'h3 : 4'hf);
            i_sfp_ctrl_model.shift(1 << k, 1'b1, 8'h00, 8 >> k, rv);
            check(rv, tx_data);
            i_sfp_ctrl_model.frame(1'b1);
            check(dl_oe, 4'h0);
            out_phase = 1'b0;
        end
        check(tx_taken, 3);
        tx_valid = 1'b0;
    endtask : t_read

    // Receiver stalls while four bytes arrive: the newest overwrites the held one
    task automatic t_fill;
        cfg.four_line_enable = 1'b0;
        width = SFP_W_SINGLE;
        i_sfp_ctrl_model.frame(1'b0);
        for (int k = 0; k < 4; k++) i_sfp_ctrl_model.shift(1, 1'b0, 8'h10 + 8'(k), 8, rv);
        i_sfp_ctrl_model.frame(1'b1);
        check(rx_overrun, 1'b1);
        pop(8'h10);
        pop(8'h11);
        pop(8'h13);
        cyc(4);
        check(rx_valid, 1'b0);
        i_sfp_ctrl_model.frame(1'b0);
        check(rx_overrun, 1'b0);
        i_sfp_ctrl_model.frame(1'b1);
    endtask : t_fill

    task automatic t_pause;
        i_sfp_ctrl_model.frame(1'b0);
        i_sfp_ctrl_model.shift(1, 1'b0, 8'h90, 4, rv);
        i_sfp_ctrl_model.hold_n = 1'b0;
        cyc(10);
        check(paused, 1'b0);
        i_sfp_ctrl_model.shift(1, 1'b0, 8'hff, 2, rv);
        check(paused, 1'b1);
        out_phase = 1'b1;
        cyc(4);
        check(dl_oe, 4'h0);
        out_phase = 1'b0;
        i_sfp_ctrl_model.hold_n = 1'b1;
        cyc(10);
        check(paused, 1'b1);
        i_sfp_ctrl_model.shift(1, 1'b0, 8'h60, 4, rv);
        i_sfp_ctrl_model.frame(1'b1);
        pop(8'h96);
        cfg.four_line_enable = 1'b1;
        i_sfp_ctrl_model.frame(1'b0);
        i_sfp_ctrl_model.hold_n = 1'b0;
        i_sfp_ctrl_model.shift(1, 1'b0, 8'h00, 2, rv);
        check(paused, 1'b0);
        i_sfp_ctrl_model.hold_n = 1'b1;
        i_sfp_ctrl_model.frame(1'b1);
    endtask : t_pause

    task automatic t_protect;
        cfg = '0;
        cfg.status_lock_bits = 2'h1;
        i_sfp_ctrl_model.wp_n = 1'b0;
        cyc(8);
        check(status_write_ok, 1'b0);
        check(region.locked, 1'b1);
        i_sfp_ctrl_model.wp_n = 1'b1;
        cyc(8);
        check(status_write_ok, 1'b1);
        cfg.status_lock_bits = 2'h2;
        cyc(8);
        check(status_write_ok, 1'b0);
        cfg.status_lock_bits = 2'h1;
        i_sfp_ctrl_model.wp_n = 1'b0;
        cfg.four_line_enable = 1'b1;
        cyc(8);
        check(status_write_ok, 1'b1);
        i_sfp_ctrl_model.wp_n = 1'b1;
        cfg = '0;
        cfg.protect_sector_granule = 1'b1;
        cfg.protect_top_bottom = 1'b1;
        cfg.protect_range_bit0 = 1'b1;
        cyc(4);
        check({region.lo, region.hi}, {11'h000, 11'h001});
        {cfg.protect_sector_granule, cfg.protect_range_bit2, cfg.protect_range_bit1} = 3'b011;
        cyc(4);
        check({region.lo, region.hi}, {11'h000, `SFP_SECTORS});
        {cfg.protect_sector_granule, cfg.protect_range_bit2, cfg.protect_range_bit1} = 3'b100;
        cfg.protect_complement = 1'b1;
        cyc(4);
        check({region.lo, region.hi}, {11'h001, `SFP_SECTORS});
    endtask : t_protect

    task automatic hold_reset(input int n, input bit shared, input logic exp);
        if (shared)
            i_sfp_ctrl_model.hold_n = 1'b0;
        else
            reset_pin_n = 1'b0;
        cyc(n);
        check(dev_reset, exp);
        i_sfp_ctrl_model.hold_n = 1'b1;
        reset_pin_n = 1'b1;
        cyc(10);
    endtask : hold_reset

    task automatic t_reset_pins;
        cfg = '0;
        internal_busy = 1'b1;
        send(1, 8'h00);
        pop(8'h00);
        check(abort_cnt, 0);
        cfg.four_line_enable = 1'b1;
        cfg.pause_or_reset_sel = 1'b1;
        hold_reset(50, 1'b0, 1'b0);
        hold_reset(`SFP_RESET_CYC + 8, 1'b0, 1'b1);
        check(abort_cnt, 1);
        internal_busy = 1'b0;
        reset_pin_fitted = 1'b0;
        hold_reset(`SFP_RESET_CYC + 8, 1'b0, 1'b0);
        reset_pin_fitted = 1'b1;
        cfg.four_line_enable = 1'b0;
        hold_reset(`SFP_RESET_CYC + 8, 1'b1, 1'b1);
        cfg.four_line_enable = 1'b1;
        hold_reset(`SFP_RESET_CYC + 8, 1'b1, 1'b0);
    endtask : t_reset_pins

    initial
    begin
        clk              = 1'b0;
        rst_n            = 1'b0;
        clk_en           = 1'b1;
        reset_pin_n      = 1'b1;
        reset_pin_fitted = 1'b1;
        cfg              = '0;
        width            = SFP_W_SINGLE;
        out_phase        = 1'b0;
        internal_busy    = 1'b0;
        rx_ready         = 1'b0;
        tx_valid         = 1'b0;
        tx_data          = 8'h00;
        repeat (4) @(negedge clk);
        check({dl_oe, selected, paused, dev_reset, status_write_ok}, 8'h01);
        @(negedge clk);
        rst_n = 1'b1;
        cyc(5);
        t_arm();
        t_freeze();
        t_widths();
        t_read();
        t_fill();
        t_pause();
        t_protect();
        t_reset_pins();
        print_verdict();
    end
endmodule : sfp_pin_front_tb_top
